// ==== design/pch_pkg.sv ====
package pch_pkg;

  // Configuration space offsets (byte addresses)
  localparam logic [7:0] OFF_CACHE = 8'h0c;
  localparam logic [7:0] OFF_BAR0 = 8'h10;
  localparam logic [7:0] OFF_BAR1 = 8'h14;
  localparam logic [7:0] OFF_SUBSYS = 8'h2c;
  localparam logic [7:0] OFF_CAP = 8'h34;
  localparam logic [7:0] OFF_IRQL = 8'h3c;
  localparam logic [7:0] OFF_EECTL = 8'hdc;
  localparam logic [7:0] OFF_EVST = 8'he0;
  localparam logic [7:0] OFF_EVMSK = 8'he4;

  // Reset values
  localparam logic [7:0] RST_CACHE = 8'h00;
  localparam logic [31:0] RST_BAR0 = 32'h0000_0001;
  localparam logic [31:0] RST_BAR1 = 32'h0000_0000;
  localparam logic [15:0] RST_SVID = 16'h0000;
  localparam logic [15:0] RST_SSID = 16'h0000;
  localparam logic [7:0] RST_CAP = 8'h00;
  localparam logic [7:0] RST_IRQL = 8'h00;
  localparam logic [7:0] IRQ_PIN_VAL = 8'h01;

  // Window sizes: low bits of each base are hardwired
  localparam logic [31:0] BAR0_RO_MASK = 32'h0000_003f;
  localparam logic [31:0] BAR1_RO_MASK = 32'h0000_0fff;

  // Serial ROM control fields
  localparam int CTL_START = 0;
  localparam int CTL_PRELOAD = 2;
  localparam int CTL_CMD = 3;
  localparam int CTL_BUSY = 5;
  localparam int CTL_PST = 6;
  localparam int CTL_ADDR = 8;
  localparam int CTL_DATA = 16;
  localparam logic [1:0] CMD_WRITE = 2'b01;
  localparam logic [1:0] CMD_READ = 2'b10;
  localparam logic [1:0] PST_NONE = 2'b00;
  localparam logic [1:0] PST_DISABLED = 2'b01;
  localparam logic [1:0] PST_BADCODE = 2'b10;
  localparam logic [1:0] PST_OK = 2'b11;

  // Preload image: word 0 check code, 1 vendor, 2 device, 3 pointer
  localparam logic [15:0] CHECK_CODE = 16'h5a5a;
  localparam logic [1:0] PRE_LAST = 2'd3;

  // Event bits
  localparam int EV_OPDONE = 0;
  localparam int EV_PREDONE = 1;

  // Serial clock timing
  localparam int CLK_NS = 4;
  localparam int SCK_HALF_NS = 500;
  localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int DIV_W = 7;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SCK_HALF_CYC - 1);
  localparam logic [4:0] BIT_LAST = 5'd25;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SHIFT = 2'b01,
    ST_DONE = 2'b11,
    ST_NEXT = 2'b10
  } pch_ee_st_t;

  typedef struct packed {
    logic sck;
    logic cs;
    logic mosi;
  } pch_ee_pins_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [7:0] cache_line;
    logic [31:0] bar0;
    logic [31:0] bar1;
    logic [15:0] svid;
    logic [15:0] ssid;
    logic [7:0] cap_ptr;
    logic [7:0] irq_line;
    logic start;
    logic preload;
    logic [1:0] cmd;
    logic busy;
    logic [1:0] pst;
    logic [7:0] ee_addr;
    logic [15:0] ee_data;
    logic [1:0] evst;
    logic [1:0] evmsk;
    logic irq;
    pch_ee_st_t st;
    logic pre_run;
    logic [1:0] pre_idx;
    logic [1:0] op;
    logic [DIV_W-1:0] div;
    logic [4:0] bitcnt;
    logic [25:0] shreg;
    pch_ee_pins_t pins;
  } pch_state_t;

  localparam pch_state_t RST_STATE = '{
    cache_line: RST_CACHE,
    bar0: RST_BAR0,
    bar1: RST_BAR1,
    svid: RST_SVID,
    ssid: RST_SSID,
    cap_ptr: RST_CAP,
    irq_line: RST_IRQL,
    st: ST_IDLE,
    default: '0
  };

endpackage : pch_pkg

// ==== design/pch_cfg_eeprom_ctl.sv ====
// Contract
// - cache line size byte, RW, reset zero
// - latency timer reads zero, ignores writes
// - header type and top byte read zero
// - I/O base, 64-byte window, resets to one
// - memory base, 4096-byte window, resets zero
// - subsystem vendor ident RO, preload may replace
// - subsystem device ident RO, preload may replace
// - capability pointer RO, preload may replace
// - interrupt line byte RW, only stored
// - interrupt pin reads one, upper half zero
// - start bit launches serial ROM cycle
// - command 01 writes, 10 reads, others reserved
// - busy bit high while access runs
// - preload enable; outcome in status bits
// - word address and data buffer fields
`timescale 1ns/1ps
`default_nettype none

module pch_cfg_eeprom_ctl (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt
  output logic irq,
  // Serial ROM
  output pch_pkg::pch_ee_pins_t ee_pins,
  input wire logic eeprom_miso,
  input wire logic eeprom_present
);

  pch_pkg::pch_state_t s;
  pch_pkg::pch_state_t n;
  logic [31:0] rd_val;
  logic hit;
  logic [31:0] merged;
  logic acc;
  logic wr;
  logic [1:0] ev;

  function automatic logic [31:0] pch_merge(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [3:0] be
  );
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction : pch_merge

  always_comb begin
    n = s;
    ev = 2'b00;
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    acc = psel && penable && !s.pready;
    wr = psel && penable && s.pready && pwrite;
    hit = 1'b1;
    // Read view of the map
    case (paddr)
      pch_pkg::OFF_CACHE: begin
        rd_val = {8'h00, 8'h00, 8'h00, s.cache_line};
      end
      pch_pkg::OFF_BAR0: begin
        rd_val = s.bar0;
      end
      pch_pkg::OFF_BAR1: begin
        rd_val = s.bar1;
      end
      pch_pkg::OFF_SUBSYS: begin
        rd_val = {s.ssid, s.svid};
      end
      pch_pkg::OFF_CAP: begin
        rd_val = {24'h00_0000, s.cap_ptr};
      end
      pch_pkg::OFF_IRQL: begin
        rd_val = {16'h0000, pch_pkg::IRQ_PIN_VAL, s.irq_line};
      end
      pch_pkg::OFF_EECTL: begin
        rd_val = {s.ee_data, s.ee_addr, s.pst, s.busy, s.cmd,
                  s.preload, 1'b0, s.start};
      end
      pch_pkg::OFF_EVST: begin
        rd_val = {30'h0000_0000, s.evst};
      end
      pch_pkg::OFF_EVMSK: begin
        rd_val = {30'h0000_0000, s.evmsk};
      end
      default: begin
        rd_val = 32'h0000_0000;
        hit = 1'b0;
      end
    endcase
    merged = pch_merge(rd_val, pwdata, pstrb);

    // Answer one cycle into the access phase
    if (acc) begin
      n.pready = 1'b1;
      n.pslverr = !hit;
      n.prdata = pwrite ? 32'h0000_0000 : rd_val;
    end

    // Writes land on the edge where the master sees pready
    if (wr) begin
      case (paddr)
        pch_pkg::OFF_CACHE: begin
          n.cache_line = merged[7:0];
        end
        pch_pkg::OFF_BAR0: begin
          n.bar0 = (merged & ~pch_pkg::BAR0_RO_MASK)
                   | pch_pkg::RST_BAR0;
        end
        pch_pkg::OFF_BAR1: begin
          n.bar1 = merged & ~pch_pkg::BAR1_RO_MASK;
        end
        pch_pkg::OFF_IRQL: begin
          n.irq_line = merged[7:0];
        end
        pch_pkg::OFF_EECTL: begin
          n.cmd = merged[pch_pkg::CTL_CMD +: 2];
          n.ee_addr = merged[pch_pkg::CTL_ADDR +: 8];
          n.ee_data = merged[pch_pkg::CTL_DATA +: 16];
          n.preload = merged[pch_pkg::CTL_PRELOAD];
          if (!s.busy && !s.start && !s.pre_run) begin
            n.start = merged[pch_pkg::CTL_START];
            if (merged[pch_pkg::CTL_PRELOAD]) begin
              n.pre_run = 1'b1;
              n.pre_idx = 2'd0;
            end
          end
        end
        pch_pkg::OFF_EVST: begin
          if (pstrb[0]) begin
            n.evst = s.evst & ~pwdata[1:0];
          end
        end
        pch_pkg::OFF_EVMSK: begin
          n.evmsk = merged[1:0];
        end
        default: begin
        end
      endcase
    end

    // Serial ROM engine
    case (s.st)
      pch_pkg::ST_IDLE: begin
        if (s.start) begin
          n.start = 1'b0;
          if (s.cmd == pch_pkg::CMD_WRITE ||
              s.cmd == pch_pkg::CMD_READ) begin
            n.shreg = {s.cmd, s.ee_addr, s.ee_data};
            n.op = s.cmd;
            n.busy = 1'b1;
            n.st = pch_pkg::ST_SHIFT;
            n.div = '0;
            n.bitcnt = 5'd0;
            n.pins.cs = 1'b1;
            n.pins.sck = 1'b0;
            n.pins.mosi = s.cmd[1];
          end
        end else if (s.pre_run) begin
          if (!eeprom_present) begin
            n.pre_run = 1'b0;
            n.pst = pch_pkg::PST_DISABLED;
            ev[pch_pkg::EV_PREDONE] = 1'b1;
          end else begin
            n.shreg = {pch_pkg::CMD_READ, 6'h00, s.pre_idx, 16'h0000};
            n.op = pch_pkg::CMD_READ;
            n.busy = 1'b1;
            n.st = pch_pkg::ST_SHIFT;
            n.div = '0;
            n.bitcnt = 5'd0;
            n.pins.cs = 1'b1;
            n.pins.sck = 1'b0;
            n.pins.mosi = pch_pkg::CMD_READ[1];
          end
        end
      end
      pch_pkg::ST_SHIFT: begin
        if (s.div == pch_pkg::DIV_LAST) begin
          n.div = '0;
          if (!s.pins.sck) begin
            n.pins.sck = 1'b1;
            n.shreg = {s.shreg[24:0], eeprom_miso};
          end else begin
            n.pins.sck = 1'b0;
            n.bitcnt = s.bitcnt + 5'd1;
            if (s.bitcnt == pch_pkg::BIT_LAST) begin
              n.st = pch_pkg::ST_DONE;
              n.pins.cs = 1'b0;
              n.pins.mosi = 1'b0;
            end else begin
              n.pins.mosi = s.shreg[25];
            end
          end
        end else begin
          n.div = s.div + 1'b1;
        end
      end
      pch_pkg::ST_DONE: begin
        n.busy = 1'b0;
        n.st = pch_pkg::ST_NEXT;
        if (s.pre_run) begin
          n.pre_idx = s.pre_idx + 2'd1;
          case (s.pre_idx)
            2'd0: begin
              if (s.shreg[15:0] != pch_pkg::CHECK_CODE) begin
                n.pre_run = 1'b0;
                n.pst = pch_pkg::PST_BADCODE;
                ev[pch_pkg::EV_PREDONE] = 1'b1;
              end
            end
            2'd1: begin
              n.svid = s.shreg[15:0];
            end
            2'd2: begin
              n.ssid = s.shreg[15:0];
            end
            default: begin
              n.cap_ptr = s.shreg[7:0];
              n.pre_run = 1'b0;
              n.pst = pch_pkg::PST_OK;
              ev[pch_pkg::EV_PREDONE] = 1'b1;
            end
          endcase
        end else begin
          if (s.op == pch_pkg::CMD_READ) begin
            n.ee_data = s.shreg[15:0];
          end
          ev[pch_pkg::EV_OPDONE] = 1'b1;
        end
      end
      pch_pkg::ST_NEXT: begin
        n.st = pch_pkg::ST_IDLE;
      end
      default: begin
        n.st = pch_pkg::ST_IDLE;
      end
    endcase

    // New events win over a clear in the same cycle
    n.evst = n.evst | ev;
    n.irq = |(n.evst & n.evmsk);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= pch_pkg::RST_STATE;
    end else begin
      s <= n;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign irq = s.irq;
  assign ee_pins = s.pins;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic rd_done;
  assign rd_done = psel && penable && pready && !pwrite;

  property p_cache_wr;
    wr && paddr == pch_pkg::OFF_CACHE && pstrb[0]
    |=> s.cache_line == $past(pwdata[7:0]);
  endproperty
  a_cache_wr: assert property (p_cache_wr)
    else $error("cache line size not stored");

  property p_lat_zero;
    rd_done && paddr == pch_pkg::OFF_CACHE |-> prdata[15:8] == 8'h00;
  endproperty
  a_lat_zero: assert property (p_lat_zero)
    else $error("latency timer not zero");

  property p_hdr_zero;
    rd_done && paddr == pch_pkg::OFF_CACHE |-> prdata[31:16] == 16'h0000;
  endproperty
  a_hdr_zero: assert property (p_hdr_zero)
    else $error("header type byte not zero");

  property p_bar0;
    wr && paddr == pch_pkg::OFF_BAR0 && pstrb == 4'hf
    |=> s.bar0 == {$past(pwdata[31:6]), 6'h01};
  endproperty
  a_bar0: assert property (p_bar0)
    else $error("io base write wrong");

  property p_bar1;
    wr && paddr == pch_pkg::OFF_BAR1 && pstrb == 4'hf
    |=> s.bar1 == {$past(pwdata[31:12]), 12'h000};
  endproperty
  a_bar1: assert property (p_bar1)
    else $error("memory base write wrong");

  property p_cap_rd;
    rd_done && paddr == pch_pkg::OFF_CAP
    |-> prdata == {24'h00_0000, s.cap_ptr};
  endproperty
  a_cap_rd: assert property (p_cap_rd)
    else $error("capability pointer read wrong");

  property p_pin_rd;
    rd_done && paddr == pch_pkg::OFF_IRQL
    |-> prdata[31:8] == 24'h00_0001;
  endproperty
  a_pin_rd: assert property (p_pin_rd)
    else $error("interrupt pin read wrong");

  property p_busy;
    s.st == pch_pkg::ST_SHIFT |-> s.busy && ee_pins.cs;
  endproperty
  a_busy: assert property (p_busy)
    else $error("busy or select low during access");

  property p_pre_off;
    s.st == pch_pkg::ST_IDLE && s.pre_run && !s.start && !eeprom_present
    |=> s.pst == pch_pkg::PST_DISABLED && !s.pre_run
        && s.evst[pch_pkg::EV_PREDONE];
  endproperty
  a_pre_off: assert property (p_pre_off)
    else $error("disabled preload outcome wrong");

  property p_no_restart;
    wr && paddr == pch_pkg::OFF_EECTL && s.busy |=> !s.start;
  endproperty
  a_no_restart: assert property (p_no_restart)
    else $error("start accepted while busy");

  property p_start_drop;
    s.st == pch_pkg::ST_IDLE && s.start && s.cmd != pch_pkg::CMD_WRITE
    && s.cmd != pch_pkg::CMD_READ |=> !s.busy && !s.start;
  endproperty
  a_start_drop: assert property (p_start_drop)
    else $error("reserved command launched a frame");

  property p_op_done;
    s.st == pch_pkg::ST_DONE && !s.pre_run
    |=> !s.busy && s.evst[pch_pkg::EV_OPDONE];
  endproperty
  a_op_done: assert property (p_op_done)
    else $error("access end not reported");

  property p_sub_ro;
    wr && paddr == pch_pkg::OFF_SUBSYS && !s.pre_run
    |=> $stable({s.ssid, s.svid});
  endproperty
  a_sub_ro: assert property (p_sub_ro)
    else $error("subsystem idents changed by a write");

  property p_irql_wr;
    wr && paddr == pch_pkg::OFF_IRQL && pstrb[0]
    |=> s.irq_line == $past(pwdata[7:0]);
  endproperty
  a_irql_wr: assert property (p_irql_wr)
    else $error("interrupt line not stored");

  c_pre_ok: cover property (s.pst == pch_pkg::PST_OK);
  c_sw_read: cover property (s.st == pch_pkg::ST_DONE && !s.pre_run
                             && s.op == pch_pkg::CMD_READ);
  c_irq: cover property ($rose(irq));
  c_pre_bad: cover property (s.pst == pch_pkg::PST_BADCODE);
  c_sw_write: cover property (s.st == pch_pkg::ST_DONE && !s.pre_run
                              && s.op == pch_pkg::CMD_WRITE);

endmodule : pch_cfg_eeprom_ctl

`default_nettype wire

// ==== tb/pch_rom_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module pch_rom_model (
  // Clock
  input wire logic pclk,
  // Serial ROM pins
  input wire pch_pkg::pch_ee_pins_t pins,
  output logic miso
);
  logic [15:0] mem [0:255];
  logic [25:0] sh = '0;
  logic [7:0] a = '0;
  int cnt = 0;

  initial miso = 1'b0;

  // Frame bits arrive MSB first on each rising serial clock
  always @(posedge pins.sck) begin
    if (pins.cs) begin
      sh <= {sh[24:0], pins.mosi};
      cnt <= cnt + 1;
    end
  end

  // Stored word goes out once command and address are in
  always @(negedge pins.sck) begin
    if (pins.cs && cnt >= 10 && cnt < 26) begin
      if (cnt == 10) a = sh[7:0];
      miso <= mem[a][25 - cnt];
    end
  end

  always @(posedge pins.cs) cnt <= 0;

  always @(negedge pins.cs) begin
    if (sh[25:24] == 2'b01) mem[sh[23:16]] <= sh[15:0];
  end

  // Line toggles every clock between frames, so it never holds the last bit
  always @(posedge pclk) begin
    if (!pins.cs) miso <= ~miso;
  end
endmodule : pch_rom_model

`default_nettype wire

// ==== tb/test_pch_cfg_eeprom_ctl.sv ====
`timescale 1ns/1ps
`default_nettype none

module test_pch_cfg_eeprom_ctl;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, irq, miso, err;
  logic present = 1'b0;
  logic [3:0] pstrb = 4'hf;
  pch_pkg::pch_ee_pins_t ee_pins;
  int miscompares = 0;
  int cmp_count = 0;
  logic [7:0] ra [9] = '{8'h0c, 8'h10, 8'h14, 8'h2c, 8'h34, 8'h3c, 8'hdc,
                         8'he0, 8'he4};
  logic [31:0] rv [9] = '{32'h0, 32'h1, 32'h0, 32'h0, 32'h0, 32'h100,
                          32'h0, 32'h0, 32'h0};
  logic [31:0] wv [6] = '{32'hff, 32'hffffffc1, 32'hfffff000, 32'h0, 32'h0,
                          32'h1ff};

  pch_cfg_eeprom_ctl dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .ee_pins(ee_pins), .eeprom_miso(miso), .eeprom_present(present)
  );

  pch_rom_model rom (.pclk(pclk), .pins(ee_pins), .miso(miso));

  always #2 pclk = ~pclk;

  task automatic apb(input logic w, input logic [7:0] ad,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only pready or the watchdog ends a wait for the answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rchk(input logic [7:0] ad, input logic [31:0] exp);
    apb(1'b0, ad, 32'h0);
    chk(rd, exp);
  endtask : rchk

  task automatic wait_ev(input int b);
    int n;
    n = 0;
    do begin
      apb(1'b0, 8'he0, 32'h0);
      n++;
    end while (rd[b] !== 1'b1 && n < 9000);
    chk({31'h0, rd[b]}, 32'h1);
  endtask : wait_ev

  task automatic t_reset;
    foreach (ra[i]) rchk(ra[i], rv[i]);
    chk({31'h0, err}, 32'h0);
  endtask : t_reset

  task automatic t_rw;
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, ra[i], 32'hffffffff);
      rchk(ra[i], wv[i]);
    end
    apb(1'b1, 8'h40, 32'hffffffff);
    chk({31'h0, err}, 32'h1);
    rchk(8'h40, 32'h0);
    chk({31'h0, err}, 32'h1);
    // Byte strobes select which bytes of a field are written
    pstrb <= 4'h2;
    apb(1'b1, 8'h0c, 32'h0000_0012);
    pstrb <= 4'hf;
    rchk(8'h0c, 32'hff);
    pstrb <= 4'h1;
    apb(1'b1, 8'h0c, 32'h0000_5634);
    pstrb <= 4'hf;
    rchk(8'h0c, 32'h34);
  endtask : t_rw

  task automatic t_ops;
    apb(1'b1, 8'hdc, 32'hbeef0509);
    apb(1'b0, 8'hdc, 32'h0);
    chk({31'h0, rd[5]}, 32'h1);
    apb(1'b1, 8'hdc, 32'h12340709);
    wait_ev(0);
    chk({16'h0, rom.mem[5]}, 32'hbeef);
    chk({16'h0, rom.mem[7]}, 32'h0);
    apb(1'b1, 8'he0, 32'h1);
    apb(1'b1, 8'he4, 32'h1);
    apb(1'b1, 8'hdc, 32'h00000511);
    wait_ev(0);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, 8'hdc, 32'h0);
    chk({16'h0, rd[31:16]}, 32'hbeef);
    chk({31'h0, rd[5]}, 32'h0);
    apb(1'b1, 8'he4, 32'h0);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, 8'he4, 32'h1);
    // Status clear needs byte lane 0
    pstrb <= 4'he;
    apb(1'b1, 8'he0, 32'h1);
    pstrb <= 4'hf;
    rchk(8'he0, 32'h1);
    apb(1'b1, 8'he0, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    rchk(8'he0, 32'h0);
    // Reserved command codes must not launch a frame
    foreach (wv[i]) if (i < 2) begin
      apb(1'b1, 8'hdc, i == 0 ? 32'h00000501 : 32'h00000519);
      repeat (3) @(posedge pclk);
      apb(1'b0, 8'hdc, 32'h0);
      chk({31'h0, rd[5]}, 32'h0);
      rchk(8'he0, 32'h0);
    end
  endtask : t_ops

  task automatic t_preload;
    apb(1'b1, 8'hdc, 32'h4);
    wait_ev(1);
    rchk(8'hdc, 32'h44);
    apb(1'b1, 8'he0, 32'h2);
    present <= 1'b1;
    apb(1'b1, 8'hdc, 32'h4);
    wait_ev(1);
    rchk(8'hdc, 32'hc4);
    rchk(8'h2c, 32'h3d4e1b2c);
    rchk(8'h34, 32'h40);
    apb(1'b1, 8'he0, 32'h3);
    apb(1'b1, 8'hdc, 32'h12340009);
    wait_ev(0);
    apb(1'b1, 8'he0, 32'h1);
    apb(1'b1, 8'hdc, 32'h4);
    wait_ev(1);
    apb(1'b0, 8'hdc, 32'h0);
    chk({30'h0, rd[7:6]}, 32'h2);
  endtask : t_preload

  task report_and_stop;
    if (miscompares == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  initial begin
    for (int i = 0; i < 256; i++) rom.mem[i] = 16'h0;
    rom.mem[0] = pch_pkg::CHECK_CODE;
    rom.mem[1] = 16'h1b2c;
    rom.mem[2] = 16'h3d4e;
    rom.mem[3] = 16'hff40;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_rw();
    t_ops();
    t_preload();
    report_and_stop();
  end

  initial begin
    repeat (95000) @(posedge pclk);
    miscompares++;
    $display("ERROR %0t: timeout", $time);
    report_and_stop();
  end
endmodule : test_pch_cfg_eeprom_ctl

`default_nettype wire
